// ---- rtl/dbpf_pkg.sv ----
package dbpf_pkg;
    // ------------------------------------------------------------------
    // Register map of the controller
    // ------------------------------------------------------------------
    localparam logic [3:0] OFS_CTRL = 4'h0;
    localparam logic [3:0] OFS_ADDR = 4'h4;
    localparam logic [3:0] OFS_WDATA = 4'h8;
    localparam logic [3:0] OFS_RDATA = 4'hc;
    localparam logic [3:0] OFS_STAT = 4'h0;
    localparam int CTRL_GO_BIT = 0;
    localparam int CTRL_WR_BIT = 1;
    localparam int CTRL_RST_BIT = 2;
    localparam int CTRL_WP_BIT = 3;
    localparam int CTRL_ACC_BIT = 4;
    localparam int CTRL_DESEL_BIT = 5;
    localparam int CTRL_PAGE_BIT = 6;
    localparam int STAT_BUSY_BIT = 0;
    localparam int STAT_RDY_BIT = 1;
    localparam int STAT_POLL_BIT = 2;
    localparam int STAT_TOG1_BIT = 3;
    localparam int STAT_TOG2_BIT = 4;
    localparam int STAT_LOCK_BIT = 5;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
    localparam int ADDR_W = 21;
    localparam int DATA_W = 16;
    localparam int PAGE_WORDS = 4;
    localparam int POLL_BIT = 7;
    localparam int TOG1_BIT = 6;
    localparam int TOG2_BIT = 2;
    // ------------------------------------------------------------------
    // Pin timing
    // ------------------------------------------------------------------
    localparam int CLK_MHZ = 100;
    localparam int T_RANDOM_NS = 100;
    localparam int T_PAGE_NS = 40;
    localparam int T_WRITE_NS = 40;
    localparam int T_RESET_NS = 500;
    localparam int CYC_RANDOM = (T_RANDOM_NS * CLK_MHZ + 999) / 1000;
    localparam int CYC_PAGE = (T_PAGE_NS * CLK_MHZ + 999) / 1000;
    localparam int CYC_WRITE = (T_WRITE_NS * CLK_MHZ + 999) / 1000;
    localparam int CYC_RESET = (T_RESET_NS * CLK_MHZ + 999) / 1000;

    typedef enum logic [4:0] {
        ST_IDLE = 5'b00001,
        ST_READ = 5'b00010,
        ST_WRITE = 5'b00100,
        ST_RESET = 5'b01000,
        ST_DONE = 5'b10000
    } dbpf_state_t;

    typedef struct packed {
        logic ce_n;
        logic we_n;
        logic oe_n;
        logic reset_n;
        logic wp_n;
        logic acc;
    } dbpf_ctl_t;
endpackage : dbpf_pkg

// ---- rtl/dbpf_host.sv ----
`timescale 1ns/1ps
module dbpf_host #(
    parameter int ADDR_W = dbpf_pkg::ADDR_W,
    parameter int DATA_W = dbpf_pkg::DATA_W
) (
    input wire logic I_CORE_CLK,
    input wire logic I_RST_B,
    input wire logic [3:0] I_AVS_ADDRESS,
    input wire logic I_AVS_READ,
    input wire logic I_AVS_WRITE,
    input wire logic [31:0] I_AVS_WRITEDATA,
    output logic [31:0] O_AVS_READDATA,
    output logic O_AVS_WAITREQUEST,
    output logic [ADDR_W-1:0] O_FL_ADDR,
    output logic [DATA_W-1:0] O_FL_DQ,
    output logic O_FL_DQ_OE,
    input wire logic [DATA_W-1:0] I_FL_DQ,
    output logic O_FL_CE_N,
    output logic O_FL_WE_N,
    output logic O_FL_OE_N,
    output logic O_FL_RESET_N,
    output logic O_FL_WP_N,
    output logic O_FL_ACC,
    input wire logic I_FL_DONE_N
);
    // ------------------------------------------------------------------
    // Register file
    // ------------------------------------------------------------------
    dbpf_pkg::dbpf_state_t state;
    dbpf_pkg::dbpf_state_t next_state;
    logic [31:0] ctrl;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic [DATA_W-1:0] rdata;
    logic [DATA_W-1:0] prev_rd;
    logic [DATA_W-1:0] dq_s1;
    logic [DATA_W-1:0] dq_s2;
    logic rdy_s1;
    logic rdy_s2;
    logic [7:0] cnt;
    logic [ADDR_W-1:0] last_page;
    logic page_valid;
    logic tog1;
    logic tog2;
    logic rd_ack;
    logic [7:0] we_low;
    logic [7:0] rst_low;
    wire busy = (state != dbpf_pkg::ST_IDLE);
    wire wr_ctrl = I_AVS_WRITE && (I_AVS_ADDRESS == dbpf_pkg::OFS_CTRL);
    wire wr_addr = I_AVS_WRITE && (I_AVS_ADDRESS == dbpf_pkg::OFS_ADDR);
    wire wr_wdata = I_AVS_WRITE && (I_AVS_ADDRESS == dbpf_pkg::OFS_WDATA);
    wire go = wr_ctrl && I_AVS_WRITEDATA[dbpf_pkg::CTRL_GO_BIT] && !busy;
    wire go_wr = I_AVS_WRITEDATA[dbpf_pkg::CTRL_WR_BIT];
    wire go_rst = I_AVS_WRITEDATA[dbpf_pkg::CTRL_RST_BIT];
    wire same_page = page_valid && I_AVS_WRITEDATA[dbpf_pkg::CTRL_PAGE_BIT]
                     && (addr[ADDR_W-1:2] == last_page[ADDR_W-1:2]);
    wire [7:0] rd_cycles = same_page ? 8'(dbpf_pkg::CYC_PAGE) : 8'(dbpf_pkg::CYC_RANDOM);
    wire [31:0] stat_word = {26'h0, rdata[dbpf_pkg::POLL_BIT], tog2, tog1,
                             rdata[dbpf_pkg::POLL_BIT], rdy_s2, busy};
    wire [31:0] rd_mux = (I_AVS_ADDRESS == dbpf_pkg::OFS_CTRL) ? stat_word :
                         (I_AVS_ADDRESS == dbpf_pkg::OFS_ADDR) ? 32'(addr) :
                         (I_AVS_ADDRESS == dbpf_pkg::OFS_WDATA) ? 32'(wdata) :
                         (I_AVS_ADDRESS == dbpf_pkg::OFS_RDATA) ? 32'(rdata) : 32'h0;

    // Reads wait one cycle so the registered data stand as waitrequest drops.
    wire rd_take = I_AVS_READ && !rd_ack;
    assign O_AVS_WAITREQUEST = rd_take;

    always_ff @(posedge I_CORE_CLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            O_AVS_READDATA <= 32'h0;
            rd_ack <= 1'b0;
        end else begin
            rd_ack <= rd_take;
            if (rd_take) begin
                O_AVS_READDATA <= rd_mux;
            end
        end
    end

    always_ff @(posedge I_CORE_CLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            ctrl <= dbpf_pkg::CTRL_RESET;
            addr <= '0;
            wdata <= '0;
        end else begin
            if (wr_ctrl && !busy) begin
                ctrl <= I_AVS_WRITEDATA;
            end
            if (wr_addr && !busy) begin
                addr <= I_AVS_WRITEDATA[ADDR_W-1:0];
            end
            if (wr_wdata && !busy) begin
                wdata <= I_AVS_WRITEDATA[DATA_W-1:0];
            end
        end
    end

    // ------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------
    always_ff @(posedge I_CORE_CLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            dq_s1 <= '0;
            dq_s2 <= '0;
            rdy_s1 <= 1'b1;
            rdy_s2 <= 1'b1;
        end else begin
            dq_s1 <= I_FL_DQ;
            dq_s2 <= dq_s1;
            rdy_s1 <= I_FL_DONE_N;
            rdy_s2 <= rdy_s1;
        end
    end

    // ------------------------------------------------------------------
    // Access sequencer
    // ------------------------------------------------------------------
    always_comb begin
        next_state = state;
        case (state)
            dbpf_pkg::ST_IDLE: begin
                if (go) begin
                    next_state = go_rst ? dbpf_pkg::ST_RESET :
                                 (go_wr ? dbpf_pkg::ST_WRITE : dbpf_pkg::ST_READ);
                end
            end
            dbpf_pkg::ST_READ: begin
                if (cnt == 8'h0) begin
                    next_state = dbpf_pkg::ST_DONE;
                end
            end
            dbpf_pkg::ST_WRITE: begin
                if (cnt == 8'h0) begin
                    next_state = dbpf_pkg::ST_DONE;
                end
            end
            dbpf_pkg::ST_RESET: begin
                if (cnt == 8'h0) begin
                    next_state = dbpf_pkg::ST_DONE;
                end
            end
            dbpf_pkg::ST_DONE: begin
                next_state = dbpf_pkg::ST_IDLE;
            end
            default: begin
                next_state = dbpf_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge I_CORE_CLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            state <= dbpf_pkg::ST_IDLE;
            cnt <= 8'h0;
        end else begin
            state <= next_state;
            if (state == dbpf_pkg::ST_IDLE && go) begin
                cnt <= go_rst ? 8'(dbpf_pkg::CYC_RESET - 1) :
                       (go_wr ? 8'(dbpf_pkg::CYC_WRITE + 1) : rd_cycles + 8'h1);
            end else if (cnt != 8'h0) begin
                cnt <= cnt - 8'h1;
            end
        end
    end

    always_ff @(posedge I_CORE_CLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            rdata <= '0;
            prev_rd <= '0;
            tog1 <= 1'b0;
            tog2 <= 1'b0;
            last_page <= '0;
            page_valid <= 1'b0;
        end else if (state == dbpf_pkg::ST_READ && cnt == 8'h0) begin
            rdata <= dq_s2;
            prev_rd <= dq_s2;
            tog1 <= dq_s2[dbpf_pkg::TOG1_BIT] ^ prev_rd[dbpf_pkg::TOG1_BIT];
            tog2 <= dq_s2[dbpf_pkg::TOG2_BIT] ^ prev_rd[dbpf_pkg::TOG2_BIT];
            last_page <= addr;
            page_valid <= 1'b1;
        end else if (state == dbpf_pkg::ST_WRITE || state == dbpf_pkg::ST_RESET) begin
            page_valid <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Flash pins
    // ------------------------------------------------------------------
    wire in_read = (state == dbpf_pkg::ST_READ);
    wire in_write = (state == dbpf_pkg::ST_WRITE);
    wire we_pulse = in_write && (cnt != 8'h0) && (cnt <= 8'(dbpf_pkg::CYC_WRITE));
    wire deselect = ctrl[dbpf_pkg::CTRL_DESEL_BIT] && !in_read && !in_write;

    always_ff @(posedge I_CORE_CLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            O_FL_ADDR <= '0;
            O_FL_DQ <= '0;
            O_FL_DQ_OE <= 1'b0;
            O_FL_CE_N <= 1'b1;
            O_FL_WE_N <= 1'b1;
            O_FL_OE_N <= 1'b1;
            O_FL_RESET_N <= 1'b1;
            O_FL_WP_N <= 1'b1;
            O_FL_ACC <= 1'b0;
        end else begin
            O_FL_ADDR <= addr;
            O_FL_DQ <= wdata;
            O_FL_DQ_OE <= in_write;
            O_FL_CE_N <= deselect || !(in_read || in_write);
            O_FL_WE_N <= !we_pulse;
            O_FL_OE_N <= !in_read;
            O_FL_RESET_N <= !(state == dbpf_pkg::ST_RESET);
            O_FL_WP_N <= !ctrl[dbpf_pkg::CTRL_WP_BIT];
            O_FL_ACC <= ctrl[dbpf_pkg::CTRL_ACC_BIT];
        end
    end

    // ------------------------------------------------------------------
    // Strobe width counters
    // ------------------------------------------------------------------
    always_ff @(posedge I_CORE_CLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            we_low <= 8'h0;
            rst_low <= 8'h0;
        end else begin
            we_low <= O_FL_WE_N ? 8'h0 : we_low + 8'h1;
            rst_low <= O_FL_RESET_N ? 8'h0 : rst_low + 8'h1;
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    a_no_contention: assert property (@(posedge I_CORE_CLK) disable iff (!I_RST_B)
        !(O_FL_DQ_OE && !O_FL_OE_N)) else $error("Data driven while outputs enabled.");
    a_oe_only_read: assert property (@(posedge I_CORE_CLK) disable iff (!I_RST_B)
        !O_FL_OE_N |-> $past(in_read)) else $error("Output enable outside read.");
    a_we_needs_ce: assert property (@(posedge I_CORE_CLK) disable iff (!I_RST_B)
        !O_FL_WE_N |-> !O_FL_CE_N && O_FL_OE_N) else $error("Write strobe without select.");
    a_reset_pulse: assert property (@(posedge I_CORE_CLK) disable iff (!I_RST_B)
        $fell(O_FL_RESET_N) |-> !O_FL_RESET_N [*8]) else $error("Reset pulse too short.");
    a_wp_follow: assert property (@(posedge I_CORE_CLK) disable iff (!I_RST_B)
        ##1 (O_FL_WP_N == !$past(ctrl[dbpf_pkg::CTRL_WP_BIT])))
        else $error("Write protect pin wrong.");

    a_we_width: assert property (@(posedge I_CORE_CLK) disable iff (!I_RST_B)
        $rose(O_FL_WE_N) |-> we_low == 8'(dbpf_pkg::CYC_WRITE))
        else $error("Write strobe width wrong.");
    a_reset_width: assert property (@(posedge I_CORE_CLK) disable iff (!I_RST_B)
        $rose(O_FL_RESET_N) |-> rst_low == 8'(dbpf_pkg::CYC_RESET))
        else $error("Reset pulse width wrong.");
    a_read_one_wait: assert property (@(posedge I_CORE_CLK) disable iff (!I_RST_B)
        O_AVS_WAITREQUEST |=> !O_AVS_WAITREQUEST)
        else $error("Read wait longer than one cycle.");
    a_reset_quiet: assert property (@(posedge I_CORE_CLK) disable iff (!I_RST_B)
        !O_FL_RESET_N |-> O_FL_CE_N && O_FL_WE_N && O_FL_OE_N)
        else $error("Strobes active during pin reset.");
    a_oe_with_ce: assert property (@(posedge I_CORE_CLK) disable iff (!I_RST_B)
        !O_FL_OE_N |-> !O_FL_CE_N && O_FL_WE_N)
        else $error("Output enable without select.");
    a_drive_in_write: assert property (@(posedge I_CORE_CLK) disable iff (!I_RST_B)
        O_FL_DQ_OE |-> $past(in_write))
        else $error("Data driven outside write.");
    a_page_timing: assert property (@(posedge I_CORE_CLK) disable iff (!I_RST_B)
        go && !go_wr && !go_rst && same_page |=> cnt == 8'(dbpf_pkg::CYC_PAGE + 1))
        else $error("Page read length wrong.");
    a_random_timing: assert property (@(posedge I_CORE_CLK) disable iff (!I_RST_B)
        go && !go_wr && !go_rst && !same_page |=> cnt == 8'(dbpf_pkg::CYC_RANDOM + 1))
        else $error("Random read length wrong.");
    a_acc_follow: assert property (@(posedge I_CORE_CLK) disable iff (!I_RST_B)
        ##1 (O_FL_ACC == $past(ctrl[dbpf_pkg::CTRL_ACC_BIT])))
        else $error("Acceleration pin wrong.");
    cov_page_hit: cover property (@(posedge I_CORE_CLK) disable iff (!I_RST_B) go && same_page);
    cov_read_wait: cover property (@(posedge I_CORE_CLK) disable iff (!I_RST_B)
        $fell(O_AVS_WAITREQUEST));
    cov_read: cover property (@(posedge I_CORE_CLK) disable iff (!I_RST_B)
        in_read ##[1:20] state == dbpf_pkg::ST_DONE);
    cov_write: cover property (@(posedge I_CORE_CLK) disable iff (!I_RST_B) $fell(O_FL_WE_N));
    cov_reset: cover property (@(posedge I_CORE_CLK) disable iff (!I_RST_B) $fell(O_FL_RESET_N));
endmodule : dbpf_host

// ---- verif/dbpf_flash_model.sv ----
`timescale 1ns/1ps
// ----------------------------------------------------------------------
// Behavioural flash device seen at its pins.
// ----------------------------------------------------------------------
module dbpf_flash_model (
    input wire logic [20:0] i_addr,
    input wire logic [15:0] i_dq,
    input wire logic i_ce_n,
    input wire logic i_we_n,
    input wire logic i_oe_n,
    input wire logic i_reset_n,
    input wire logic i_wp_n,
    output logic [15:0] o_dq,
    output logic o_done_n
);
    logic [15:0] mem [0:63];
    logic busy = 1'b0;
    logic [63:0] prot = 64'h0;
    logic vcc_low = 1'b0;
    wire [15:0] word = mem[i_addr[5:0]];
    wire boot = (i_addr == 21'h0) || (i_addr == 21'h1fffff);
    wire blocked = (boot && !i_wp_n) || prot[i_addr[5:0]] || vcc_low;
    initial begin
        for (int i = 0; i < 64; i++) begin
            mem[i] = 16'hffff;
        end
    end
    // Released bus shows the inverse so a stale capture cannot pass.
    assign o_dq = (!i_ce_n && !i_oe_n) ? word : ~word;
    assign o_done_n = ~busy;
    always @(posedge i_we_n) begin
        if (!i_ce_n && i_reset_n && !blocked) begin
            mem[i_addr[5:0]] = i_dq;
            busy = 1'b1;
        end
    end
    always @(posedge busy) begin
        #200;
        busy = 1'b0;
    end
    always @(negedge i_reset_n) begin
        busy = 1'b0;
    end
endmodule : dbpf_flash_model

// ---- verif/dual_bank_page_flash_control_tb.sv ----
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin mismatches++; \
    $display("MISMATCH %s exp %h got %h", nm, e, g); end end
module dual_bank_page_flash_control_tb;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic [3:0] address = 4'h0;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic [31:0] wdata = 32'h0;
    logic [31:0] rdata;
    logic waitreq;
    logic [20:0] fl_addr;
    logic [15:0] fl_dq_o;
    logic [15:0] dev_dq;
    logic fl_dq_oe, ce_n, we_n, oe_n, reset_n, wp_n, acc, done_n;
    wire [15:0] fl_dq = fl_dq_oe ? fl_dq_o : dev_dq;
    int mismatches = 0;
    int n_tests = 0;
    int cyc = 0;
    int rst_cnt = 0;
    int oe_cnt = 0;
    logic acc_seen = 1'b0;
    logic [31:0] s;
    always #5 clk = ~clk;
    dbpf_host dut_u (.I_CORE_CLK(clk), .I_RST_B(rst_b), .I_AVS_ADDRESS(address),
        .I_AVS_READ(rd), .I_AVS_WRITE(wr), .I_AVS_WRITEDATA(wdata), .O_AVS_READDATA(rdata),
        .O_AVS_WAITREQUEST(waitreq), .O_FL_ADDR(fl_addr), .O_FL_DQ(fl_dq_o),
        .O_FL_DQ_OE(fl_dq_oe), .I_FL_DQ(fl_dq), .O_FL_CE_N(ce_n), .O_FL_WE_N(we_n),
        .O_FL_OE_N(oe_n), .O_FL_RESET_N(reset_n), .O_FL_WP_N(wp_n), .O_FL_ACC(acc),
        .I_FL_DONE_N(done_n));
    dbpf_flash_model fl_u (.i_addr(fl_addr), .i_dq(fl_dq), .i_ce_n(ce_n), .i_we_n(we_n),
        .i_oe_n(oe_n), .i_reset_n(reset_n), .i_wp_n(wp_n), .o_dq(dev_dq), .o_done_n(done_n));
    // ------------------------------------------------------------------
    // Monitors and timeout.
    // ------------------------------------------------------------------
    always @(posedge clk) begin
        cyc++;
        if (reset_n === 1'b0) rst_cnt++;
        if (oe_n === 1'b0) oe_cnt++;
        if (acc === 1'b1) acc_seen = 1'b1;
        if (cyc == 20000) begin
            mismatches++;
            tally_and_finish();
        end
    end
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : tally_and_finish
    // ------------------------------------------------------------------
    // Bus tasks.
    // ------------------------------------------------------------------
    task automatic av_wr(input logic [3:0] a, input logic [31:0] d);
        address <= a;
        wdata <= d;
        wr <= 1'b1;
        do @(posedge clk); while (waitreq !== 1'b0);
        wr <= 1'b0;
        @(posedge clk);
    endtask : av_wr
    task automatic av_rd(input logic [3:0] a, output logic [31:0] d);
        address <= a;
        rd <= 1'b1;
        do @(posedge clk); while (waitreq !== 1'b0);
        d = rdata;
        rd <= 1'b0;
        @(posedge clk);
    endtask : av_rd
    task automatic op(input logic [20:0] a, input logic [15:0] d, input logic [31:0] c);
        av_wr(dbpf_pkg::OFS_ADDR, {11'h0, a});
        av_wr(dbpf_pkg::OFS_WDATA, {16'h0, d});
        av_wr(dbpf_pkg::OFS_CTRL, c);
        s = 32'h1;
        for (int i = 0; i < 200 && s[dbpf_pkg::STAT_BUSY_BIT] !== 1'b0; i++) begin
            av_rd(dbpf_pkg::OFS_STAT, s);
        end
        `CHK("busy", 1'b0, s[dbpf_pkg::STAT_BUSY_BIT])
    endtask : op
    // ------------------------------------------------------------------
    // Main sequence.
    // ------------------------------------------------------------------
    initial begin
        repeat (6) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        `CHK("ce_n", 1'b1, ce_n)
        `CHK("oe_n", 1'b1, oe_n)
        `CHK("dq_oe", 1'b0, fl_dq_oe)
        av_rd(dbpf_pkg::OFS_STAT, s);
        `CHK("rdy", 1'b1, s[dbpf_pkg::STAT_RDY_BIT])
        op(21'h5, 16'h12b4, 32'h3);
        `CHK("mem5", 16'h12b4, fl_u.mem[5])
        av_rd(dbpf_pkg::OFS_STAT, s);
        `CHK("rdy_busy", 1'b0, s[dbpf_pkg::STAT_RDY_BIT])
        repeat (30) @(posedge clk);
        av_rd(dbpf_pkg::OFS_STAT, s);
        `CHK("rdy_back", 1'b1, s[dbpf_pkg::STAT_RDY_BIT])
        oe_cnt = 0;
        op(21'h5, 16'h0, 32'h1);
        `CHK("rand_cyc", dbpf_pkg::CYC_RANDOM + 2, oe_cnt)
        av_rd(dbpf_pkg::OFS_RDATA, s);
        `CHK("rd5", 16'h12b4, s[15:0])
        av_rd(dbpf_pkg::OFS_STAT, s);
        `CHK("poll", 1'b1, s[dbpf_pkg::STAT_POLL_BIT])
        `CHK("lock1", 1'b1, s[dbpf_pkg::STAT_LOCK_BIT])
        op(21'h6, 16'h0055, 32'h13);
        `CHK("acc", 1'b1, acc_seen)
        `CHK("mem5_kept", 16'h12b4, fl_u.mem[5])
        repeat (30) @(posedge clk);
        op(21'h6, 16'h0, 32'h41);
        av_rd(dbpf_pkg::OFS_RDATA, s);
        `CHK("page6", 16'h0055, s[15:0])
        av_rd(dbpf_pkg::OFS_STAT, s);
        `CHK("lock0", 1'b0, s[dbpf_pkg::STAT_LOCK_BIT])
        oe_cnt = 0;
        op(21'h7, 16'h0, 32'h41);
        `CHK("page_cyc", dbpf_pkg::CYC_PAGE + 2, oe_cnt)
        av_rd(dbpf_pkg::OFS_RDATA, s);
        `CHK("page7", 16'hffff, s[15:0])
        op(21'h0, 16'h0, 32'hb);
        repeat (30) @(posedge clk);
        `CHK("mem0", 16'hffff, fl_u.mem[0])
        fl_u.prot[9] = 1'b1;
        op(21'h9, 16'h1234, 32'h3);
        `CHK("mem9", 16'hffff, fl_u.mem[9])
        fl_u.vcc_low = 1'b1;
        op(21'ha, 16'h1234, 32'h3);
        `CHK("mem10", 16'hffff, fl_u.mem[10])
        fl_u.vcc_low = 1'b0;
        rst_cnt = 0;
        op(21'h0, 16'h0, 32'h5);
        `CHK("rst_len", 50, rst_cnt)
        tally_and_finish();
    end
endmodule : dual_bank_page_flash_control_tb
